// *** src/prediction_restrict_ctx_decode.sv ***
// decoder and access checker for the two restriction-by-context instructions
// assumes the pipeline presents one instruction per cycle with its current context,
// and the prediction resources acknowledge each restriction request once
//
// Local design decisions: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module prediction_restrict_ctx_decode
   import prediction_restrict_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // AHB-Lite register slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // instruction issue from the pipeline
   input wire logic instValid,
   input wire sys_enc_t instEnc,
   input wire logic [63:0] instOperand,
   input wire logic [1:0] curLevel,
   input wire logic [1:0] curSecurity,
   input wire logic [15:0] curSpaceTag,
   input wire logic [15:0] curGuest,
   // outcome back to the pipeline
   output logic resultValid,
   output result_t result,
   // prediction and cache allocation resources
   output logic restrictValid,
   output restrict_t restrictReq,
   input wire logic restrictAck,
   // barrier completion handshake
   input wire logic barrierReq,
   output logic barrierDone
);

   // software-visible configuration
   logic [3:0] hypConfig; // hyp enable, host extension, trap general, nested virt
   logic [1:0] sysControl; // ctx_restrict_enable for level 1 and level 2
   logic secureConfig; // fine_trap_enable
   logic [1:0] fineTrap; // flow and prefetch fine-grained trap bits
   logic [4:0] features; // implemented options
   logic [7:0] performCount; // restrictions sent, wraps
   logic pending; // a restriction is not yet acknowledged
   logic barrierWait; // a barrier waits on pending work

   // bus data phase state
   logic dataWrite;
   logic [7:0] dataAddr;
   logic accept;
   logic [31:0] readWord;

   // named views of the configuration
   logic hypEnabled, hostExtension, trapGeneral, nestedVirt;
   logic ctxEnableL1, ctxEnableL2, fineTrapEnable;
   logic specFeature, realmFeature, fineFeature, level3Present, secureImpl;
   logic hostMode, fineOk, fineBit;

   // decode results
   logic isFlow, isPrefetch, hit;
   logic [1:0] targetLevel;
   outcome_t next_outcome;
   logic [1:0] next_trapLevel;
   logic [1:0] next_pair;
   logic pairReserved;
   logic next_allTag, next_allGuest;
   logic [15:0] next_tag, next_guest;
   logic next_issue;

   assign hypEnabled = hypConfig[HYP_ENABLE_BIT];
   assign hostExtension = hypConfig[HOST_EXTENSION_BIT];
   assign trapGeneral = hypConfig[TRAP_GENERAL_BIT];
   assign nestedVirt = hypConfig[NESTED_VIRT_BIT];
   assign ctxEnableL1 = sysControl[CTX_ENABLE_L1_BIT];
   assign ctxEnableL2 = sysControl[CTX_ENABLE_L2_BIT];
   assign fineTrapEnable = secureConfig;
   assign specFeature = features[FEAT_SPEC_BIT];
   assign realmFeature = features[FEAT_REALM_BIT];
   assign fineFeature = features[FEAT_FINE_BIT];
   assign level3Present = features[FEAT_LEVEL3_BIT];
   assign secureImpl = features[FEAT_SECURE_BIT];
   assign hostMode = hypEnabled & hostExtension & trapGeneral;
   assign fineOk = fineFeature & (~level3Present | fineTrapEnable);
   assign accept = hsel & hready & htrans[1];

   // bus address phase capture; only whole-word writes are stored
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dataWrite <= 1'b0;
         dataAddr <= 8'h00;
      end else if (accept) begin
         dataWrite <= hwrite & (hsize == HSIZE_WORD);
         dataAddr <= haddr[7:0];
      end else begin
         dataWrite <= 1'b0;
      end
   end

   // zero-wait slave, always OKAY
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hreadyout <= 1'b1;
         hresp <= HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp <= HRESP_OKAY;
      end
   end

   // read mux; unmapped offsets read as zero
   always_comb begin
      readWord = 32'h0000_0000;
      unique case (haddr[7:0])
         ADDR_HYP_CONFIG: readWord = {28'h0000000, hypConfig};
         ADDR_SYS_CONTROL: readWord = {30'h00000000, sysControl};
         ADDR_SECURE_CONFIG: readWord = {31'h00000000, secureConfig};
         ADDR_FINE_TRAP: readWord = {30'h00000000, fineTrap};
         ADDR_FEATURES: readWord = {27'h0000000, features};
         ADDR_STATUS: readWord = {16'h0000, performCount, 2'h0, barrierWait, pending,
                                  result.trapLevel, result.outcome};
         default: readWord = 32'h0000_0000;
      endcase
   end

   // read data registered at the address phase so it stands in the data phase
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= 32'h0000_0000;
      end else if (accept && !hwrite) begin
         hrdata <= readWord;
      end else begin
         hrdata <= 32'h0000_0000;
      end
   end

   // configuration writes in the data phase; the status word is read-only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hypConfig <= HYP_CONFIG_RST;
         sysControl <= SYS_CONTROL_RST;
         secureConfig <= SECURE_CONFIG_RST;
         fineTrap <= FINE_TRAP_RST;
         features <= FEATURES_RST;
      end else if (dataWrite) begin
         if (dataAddr == ADDR_HYP_CONFIG) hypConfig <= hwdata[3:0];
         if (dataAddr == ADDR_SYS_CONTROL) sysControl <= hwdata[1:0];
         if (dataAddr == ADDR_SECURE_CONFIG) secureConfig <= hwdata[0];
         if (dataAddr == ADDR_FINE_TRAP) fineTrap <= hwdata[1:0];
         if (dataAddr == ADDR_FEATURES) features <= hwdata[4:0];
      end
   end

   // instruction recognition; the two variants differ only in op2
   assign isFlow = (instEnc.op0 == ENC_OP0) && (instEnc.op1 == ENC_OP1) &&
                   (instEnc.crn == ENC_CRN) && (instEnc.crm == ENC_CRM) &&
                   (instEnc.op2 == ENC_OP2_FLOW);
   assign isPrefetch = (instEnc.op0 == ENC_OP0) && (instEnc.op1 == ENC_OP1) &&
                       (instEnc.crn == ENC_CRN) && (instEnc.crm == ENC_CRM) &&
                       (instEnc.op2 == ENC_OP2_PREFETCH);
   assign hit = instValid & (isFlow | isPrefetch);
   assign fineBit = isPrefetch ? fineTrap[PREFETCH_TRAP_BIT] : fineTrap[FLOW_TRAP_BIT];
   assign targetLevel = instOperand[LEVEL_MSB:LEVEL_LSB];

   // effective security pair from operand and current state
   always_comb begin
      next_pair = PAIR_SECURE;
      pairReserved = 1'b0;
      if (realmFeature) begin
         unique case (curSecurity)
            PAIR_SECURE: next_pair = {1'b0, instOperand[NONSECURE_BIT]};
            PAIR_NONSECURE: next_pair = PAIR_NONSECURE;
            PAIR_REALM: next_pair = PAIR_REALM;
            PAIR_ROOT: next_pair = {instOperand[SECURITY_EXT_BIT],
                                    instOperand[NONSECURE_BIT]};
         endcase
         pairReserved = (next_pair == PAIR_SECURE) && !secureImpl;
      end else begin
         // upper bit is reserved-zero; non-secure code cannot name secure
         next_pair = {1'b0, (curSecurity == PAIR_NONSECURE) | instOperand[NONSECURE_BIT]};
      end
   end

   // access checks, then the nop cases
   always_comb begin
      next_outcome = OUT_PERFORM;
      next_trapLevel = LEVEL0;
      if (!specFeature) begin
         next_outcome = OUT_UNDEF;
      end else begin
         unique case (curLevel)
            LEVEL0: begin
               if (!hostMode && !ctxEnableL1) begin
                  next_outcome = OUT_TRAP;
                  next_trapLevel = (hypEnabled && trapGeneral) ? LEVEL2 : LEVEL1;
               end else if (hypEnabled && !(hostExtension && trapGeneral) && fineOk && fineBit) begin
                  next_outcome = OUT_TRAP;
                  next_trapLevel = LEVEL2;
               end else if (hostMode && !ctxEnableL2) begin
                  next_outcome = OUT_TRAP;
                  next_trapLevel = LEVEL2;
               end
            end
            LEVEL1: begin
               // nested virtualisation is checked ahead of the fine-grained bit
               if (hypEnabled && nestedVirt) begin
                  next_outcome = OUT_TRAP;
                  next_trapLevel = LEVEL2;
               end else if (hypEnabled && fineOk && fineBit) begin
                  next_outcome = OUT_TRAP;
                  next_trapLevel = LEVEL2;
               end
            end
            LEVEL2: begin
               next_outcome = OUT_PERFORM;
            end
            LEVEL3: begin
               next_outcome = OUT_PERFORM;
            end
         endcase
         if (next_outcome == OUT_PERFORM) begin
            if (targetLevel > curLevel) begin
               next_outcome = OUT_NOP;
            end else if ((curLevel == LEVEL3) && (pairReserved ||
                         ((next_pair == PAIR_ROOT) && (targetLevel != LEVEL3)))) begin
               next_outcome = OUT_NOP;
            end
         end
      end
   end

   // context fields after effective values and reserved-zero handling
   always_comb begin
      next_allTag = (curLevel != LEVEL0) && (targetLevel == LEVEL0) &&
                    instOperand[ALL_TAG_BIT];
      if (curLevel == LEVEL0) begin
         next_tag = curSpaceTag;
      end else if ((targetLevel == LEVEL0) && !next_allTag) begin
         next_tag = instOperand[TAG_MSB:TAG_LSB];
      end else begin
         next_tag = 16'h0000;
      end
      next_allGuest = curLevel[1] && !targetLevel[1] && hypEnabled &&
                      instOperand[ALL_GUEST_BIT];
      if ((curLevel == LEVEL1) || ((curLevel == LEVEL0) && !hostMode)) begin
         next_guest = curGuest;
      end else if (curLevel == LEVEL0) begin
         next_guest = 16'h0000;
      end else if (hypEnabled && !next_allGuest && ((targetLevel == LEVEL1) ||
                   ((targetLevel == LEVEL0) && !hostMode))) begin
         next_guest = instOperand[GUEST_MSB:GUEST_LSB];
      end else begin
         next_guest = 16'h0000;
      end
   end

   assign next_issue = hit && (next_outcome == OUT_PERFORM);

   // outcome report, one pulse per recognised instruction
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         resultValid <= 1'b0;
         result <= '0;
      end else begin
         resultValid <= hit;
         if (hit) begin
            result.outcome <= next_outcome;
            result.trapLevel <= next_trapLevel;
            result.syndrome <= (next_outcome == OUT_TRAP) ? SYNDROME_CLASS : 6'h00;
            result.kind <= isPrefetch ? KIND_PREFETCH : KIND_FLOW;
         end
      end
   end

   // restriction request; resources may meet it without invalidating state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         restrictValid <= 1'b0;
         restrictReq <= '0;
      end else begin
         restrictValid <= next_issue;
         if (next_issue) begin
            restrictReq.kind <= isPrefetch ? KIND_PREFETCH : KIND_FLOW;
            restrictReq.coverIcache <= isPrefetch;
            restrictReq.coverDcache <= isPrefetch;
            restrictReq.coverTlb <= isPrefetch;
            restrictReq.allSpaceTag <= next_allTag;
            restrictReq.spaceTag <= next_tag;
            restrictReq.allGuest <= next_allGuest;
            restrictReq.guestIdent <= next_guest;
            restrictReq.secPair <= next_pair;
            restrictReq.targetLevel <= targetLevel;
         end
      end
   end

   // outstanding work; a new request in the ack cycle keeps it pending
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pending <= 1'b0;
         performCount <= 8'h00;
      end else begin
         if (next_issue) begin
            pending <= 1'b1;
            performCount <= performCount + 8'h01;
         end else if (restrictAck) begin
            pending <= 1'b0;
         end
      end
   end

   // barrier completes only once nothing is outstanding
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         barrierWait <= 1'b0;
         barrierDone <= 1'b0;
      end else begin
         barrierDone <= (barrierReq | barrierWait) & ~pending & ~next_issue;
         barrierWait <= (barrierReq | barrierWait) & (pending | next_issue);
      end
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_undef_no_feature: assert property (
      hit && !specFeature |=> resultValid && (result.outcome == OUT_UNDEF) && !restrictValid)
      else $error("undefined case not reported");
   a_el0_enable_trap: assert property (
      hit && specFeature && (curLevel == LEVEL0) && !hostMode && !ctxEnableL1 |=>
      (result.outcome == OUT_TRAP) && (result.syndrome == SYNDROME_CLASS) &&
      (result.trapLevel == (($past(hypEnabled) && $past(trapGeneral)) ? LEVEL2 : LEVEL1)))
      else $error("level 0 enable trap wrong");
   a_host_enable_trap: assert property (
      hit && specFeature && (curLevel == LEVEL0) && hostMode && !ctxEnableL2 |=>
      (result.outcome == OUT_TRAP) && (result.trapLevel == LEVEL2))
      else $error("host mode trap missing");
   a_nested_first: assert property (
      hit && specFeature && (curLevel == LEVEL1) && hypEnabled && nestedVirt |=>
      (result.outcome == OUT_TRAP) && (result.trapLevel == LEVEL2) &&
      (result.syndrome == SYNDROME_CLASS))
      else $error("nested trap missing");
   a_fine_trap_l1: assert property (
      hit && specFeature && (curLevel == LEVEL1) && hypEnabled && !nestedVirt &&
      fineOk && fineBit |=> (result.outcome == OUT_TRAP) && (result.trapLevel == LEVEL2))
      else $error("fine-grained trap missing");
   a_high_no_trap: assert property (
      hit && specFeature && curLevel[1] |=> resultValid && (result.outcome != OUT_TRAP))
      else $error("trap at high level");
   a_lower_nop: assert property (
      hit && specFeature && (curLevel == LEVEL2) && (targetLevel == LEVEL3) |=>
      (result.outcome == OUT_NOP) && !restrictValid)
      else $error("target above current not nop");
   a_root_pair_nop: assert property (
      hit && specFeature && realmFeature && (curLevel == LEVEL3) &&
      (curSecurity == PAIR_ROOT) && (instOperand[NONSECURE_BIT +: 2] == PAIR_ROOT) &&
      (targetLevel != LEVEL3) |=> (result.outcome == OUT_NOP))
      else $error("root pair not nop");
   a_low_tag_current: assert property (
      restrictValid && ($past(curLevel) == LEVEL0) |->
      (restrictReq.spaceTag == $past(curSpaceTag)) && !restrictReq.allSpaceTag)
      else $error("level 0 tag not current");
   a_guest_sel_zero: assert property (
      restrictValid && !$past(curLevel[1]) |-> !restrictReq.allGuest)
      else $error("all-guest not zero");
   a_realm_pair: assert property (
      restrictValid && $past(realmFeature) && ($past(curSecurity) == PAIR_REALM) |->
      (restrictReq.secPair == PAIR_REALM))
      else $error("realm pair not forced");
   a_prefetch_cover: assert property (
      restrictValid && (restrictReq.kind == KIND_PREFETCH) |->
      restrictReq.coverIcache && restrictReq.coverDcache && restrictReq.coverTlb)
      else $error("prefetch coverage incomplete");
   a_barrier_order: assert property (
      barrierDone |-> !$past(pending) && !$past(next_issue))
      else $error("barrier done with work outstanding");
   a_barrier_free: assert property (
      barrierReq && !pending && !next_issue |=> barrierDone)
      else $error("idle barrier not completed");

   c_prefetch_done: cover property (restrictValid && (restrictReq.kind == KIND_PREFETCH));
   c_trap_l2: cover property (resultValid && (result.outcome == OUT_TRAP) &&
                              (result.trapLevel == LEVEL2));
   c_nop: cover property (resultValid && (result.outcome == OUT_NOP));
   c_barrier_wait: cover property (restrictValid ##1 barrierReq ##[1:20] barrierDone);

endmodule : prediction_restrict_ctx_decode

`default_nettype wire

// *** src/prediction_restrict_pkg.sv ***
// constants, encodings and carriers for the prediction restriction decoder
// assumes a single core clock domain and an AHB-Lite register bus
package prediction_restrict_pkg;

   // system instruction encoding fields
   localparam logic [1:0] ENC_OP0 = 2'h1;
   localparam logic [2:0] ENC_OP1 = 3'h3;
   localparam logic [3:0] ENC_CRN = 4'h7;
   localparam logic [3:0] ENC_CRM = 4'h3;
   localparam logic [2:0] ENC_OP2_FLOW = 3'h4;
   localparam logic [2:0] ENC_OP2_PREFETCH = 3'h7;

   // operand field positions
   localparam int TAG_LSB = 0;
   localparam int TAG_MSB = 15;
   localparam int ALL_TAG_BIT = 16;
   localparam int LEVEL_LSB = 24;
   localparam int LEVEL_MSB = 25;
   localparam int NONSECURE_BIT = 26;
   localparam int SECURITY_EXT_BIT = 27;
   localparam int GUEST_LSB = 32;
   localparam int GUEST_MSB = 47;
   localparam int ALL_GUEST_BIT = 48;

   // exception levels
   localparam logic [1:0] LEVEL0 = 2'h0;
   localparam logic [1:0] LEVEL1 = 2'h1;
   localparam logic [1:0] LEVEL2 = 2'h2;
   localparam logic [1:0] LEVEL3 = 2'h3;

   // security pair {security_ext_bit, nonsecure_bit}, also the current-state code
   localparam logic [1:0] PAIR_SECURE = 2'h0;
   localparam logic [1:0] PAIR_NONSECURE = 2'h1;
   localparam logic [1:0] PAIR_ROOT = 2'h2;
   localparam logic [1:0] PAIR_REALM = 2'h3;

   // trap syndrome class
   localparam logic [5:0] SYNDROME_CLASS = 6'h18;

   // register byte offsets (low address byte decoded)
   localparam logic [7:0] ADDR_HYP_CONFIG = 8'h00;
   localparam logic [7:0] ADDR_SYS_CONTROL = 8'h04;
   localparam logic [7:0] ADDR_SECURE_CONFIG = 8'h08;
   localparam logic [7:0] ADDR_FINE_TRAP = 8'h0C;
   localparam logic [7:0] ADDR_FEATURES = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;

   // register field positions
   localparam int HYP_ENABLE_BIT = 0;
   localparam int HOST_EXTENSION_BIT = 1;
   localparam int TRAP_GENERAL_BIT = 2;
   localparam int NESTED_VIRT_BIT = 3;
   localparam int CTX_ENABLE_L1_BIT = 0;
   localparam int CTX_ENABLE_L2_BIT = 1;
   localparam int FLOW_TRAP_BIT = 0;
   localparam int PREFETCH_TRAP_BIT = 1;
   localparam int FEAT_SPEC_BIT = 0;
   localparam int FEAT_REALM_BIT = 1;
   localparam int FEAT_FINE_BIT = 2;
   localparam int FEAT_LEVEL3_BIT = 3;
   localparam int FEAT_SECURE_BIT = 4;

   // register reset values
   localparam logic [3:0] HYP_CONFIG_RST = 4'h0;
   localparam logic [1:0] SYS_CONTROL_RST = 2'h0;
   localparam logic SECURE_CONFIG_RST = 1'b0;
   localparam logic [1:0] FINE_TRAP_RST = 2'h0;
   localparam logic [4:0] FEATURES_RST = 5'h1F;

   // bus constants
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'b0;

   typedef enum logic [1:0] {OUT_PERFORM, OUT_NOP, OUT_TRAP, OUT_UNDEF} outcome_t;
   typedef enum logic {KIND_FLOW, KIND_PREFETCH} restrict_kind_t;

   typedef struct packed {
      logic [1:0] op0;
      logic [2:0] op1;
      logic [3:0] crn;
      logic [3:0] crm;
      logic [2:0] op2;
   } sys_enc_t;

   typedef struct packed {
      outcome_t outcome;
      logic [1:0] trapLevel;
      logic [5:0] syndrome;
      restrict_kind_t kind;
   } result_t;

   typedef struct packed {
      restrict_kind_t kind;
      logic coverIcache;
      logic coverDcache;
      logic coverTlb;
      logic allSpaceTag;
      logic [15:0] spaceTag;
      logic allGuest;
      logic [15:0] guestIdent;
      logic [1:0] secPair;
      logic [1:0] targetLevel;
   } restrict_t;

endpackage : prediction_restrict_pkg

// *** verification/restrict_resources_model.sv ***
// model of the prediction resources that acknowledge each restriction
// assumes restrictValid is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module restrict_resources_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // restriction handshake
   input wire logic restrictValid,
   input wire logic slow,
   output logic restrictAck
);
   logic [2:0] delay; // cycles left before the ack
   // a slow flush holds the barrier back, which the bench relies on
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         delay <= 3'h0;
         restrictAck <= 1'b0;
      end else begin
         restrictAck <= (delay == 3'h1);
         if (restrictValid) delay <= slow ? 3'h4 : 3'h1;
         else if (delay != 3'h0) delay <= delay - 3'h1;
      end
   end
endmodule : restrict_resources_model
`default_nettype wire

// *** verification/prediction_restrict_ctx_decode_test.sv ***
// bench for the restriction decoder: bus tasks, issue task, result queue
// assumes one bus slave and the resource model on the far side
`timescale 1ns/1ps
`default_nettype none
module prediction_restrict_ctx_decode_test
   import prediction_restrict_pkg::*;
();
   logic clk = 0, rst_n = 0, hwrite = 0, hreadyout, hresp, instValid = 0, slow = 0;
   logic restrictValid, restrictAck, barrierReq = 0, barrierDone, resultValid;
   logic [1:0] htrans = 0, curLevel = 0, curSecurity = PAIR_NONSECURE;
   logic [1:0] opPair = 2'h1; // operand security pair, bits 27..26
   logic [31:0] haddr = 0, hwdata = 0, hrdata;
   logic [63:0] instOperand = 0;
   logic [15:0] curSpaceTag = 0;
   sys_enc_t instEnc = '0;
   result_t result;
   restrict_t restrictReq;
   result_t expQ[$]; // outcomes still owed
   int mismatches = 0, compares = 0;
   always #10 clk = ~clk;
   prediction_restrict_ctx_decode DUT (.clk(clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .instValid(instValid), .instEnc(instEnc), .instOperand(instOperand),
      .curLevel(curLevel), .curSecurity(curSecurity), .curSpaceTag(curSpaceTag),
      .curGuest(16'h0042), .resultValid(resultValid), .result(result),
      .restrictValid(restrictValid), .restrictReq(restrictReq), .restrictAck(restrictAck),
      .barrierReq(barrierReq), .barrierDone(barrierDone));
   restrict_resources_model model (.clk(clk), .rst_n(rst_n),
      .restrictValid(restrictValid), .slow(slow), .restrictAck(restrictAck));
   // compare and count
   task automatic chk(input string what, input logic [41:0] seen, input logic [41:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // verdict and end of run
   task automatic complete_run();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : complete_run
   // wait for hready high at a rising edge, bounded
   task automatic waitReady();
      for (int n = 0; n < 20; n++) begin
         @(posedge clk);
         if (hreadyout === 1'b1) return;
      end
      mismatches++;
      complete_run();
   endtask : waitReady
   // single word transfer; a read compares its data phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      waitReady();
      htrans <= 2'h0;
      hwdata <= d;
      waitReady();
      chk("hresp", hresp, HRESP_OKAY);
      if (!w) chk("hrdata", hrdata, d);
   endtask : bus
   // issue one instruction and note the outcome owed
   task automatic iss(input logic [2:0] op2, input logic [1:0] lvl, input logic [1:0] tgt,
         input outcome_t out, input logic [1:0] tl);
      instEnc <= '{ENC_OP0, ENC_OP1, ENC_CRN, ENC_CRM, op2};
      instOperand <= {$urandom, $urandom} & ~64'h0F00FF00
         | {36'h0, opPair, tgt, 24'h0};
      curLevel <= lvl;
      curSpaceTag <= 16'($urandom);
      instValid <= 1'b1;
      expQ.push_back('{out, tl, (out == OUT_TRAP) ? SYNDROME_CLASS : 6'h00,
         restrict_kind_t'(op2 == ENC_OP2_PREFETCH)});
      @(posedge clk);
      instValid <= 1'b0;
      @(posedge clk);
   endtask : iss
   // every result pulse takes the oldest note
   always @(negedge clk) begin
      result_t e;
      if (resultValid === 1'b1) begin
         if (expQ.size() > 0) begin
            e = expQ.pop_front();
            chk("result", result, e);
            chk("restrictValid", restrictValid, e.outcome == OUT_PERFORM);
         end else chk("extra result", 1, 0);
      end
   end
   initial begin
      logic [2:0] op;
      void'($urandom(32213));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      bus(0, ADDR_FEATURES, {27'h0, FEATURES_RST});
      bus(0, 8'h40, 32'h0);
      for (int k = 0; k < 2; k++) begin
         op = k ? ENC_OP2_PREFETCH : ENC_OP2_FLOW;
         iss(op, LEVEL2, LEVEL0, OUT_PERFORM, 2'h0);
         iss(op, LEVEL3, LEVEL3, OUT_PERFORM, 2'h0);
         iss(op, LEVEL1, LEVEL2, OUT_NOP, 2'h0);
         iss(op, LEVEL0, LEVEL0, OUT_TRAP, LEVEL1);
      end
      bus(1, ADDR_HYP_CONFIG, 32'h5);
      iss(ENC_OP2_FLOW, LEVEL0, LEVEL0, OUT_TRAP, LEVEL2);
      bus(1, ADDR_SECURE_CONFIG, 32'h1);
      bus(1, ADDR_FINE_TRAP, 32'h3);
      bus(1, ADDR_HYP_CONFIG, 32'h9);
      iss(ENC_OP2_PREFETCH, LEVEL1, LEVEL0, OUT_TRAP, LEVEL2);
      bus(1, ADDR_HYP_CONFIG, 32'h1);
      iss(ENC_OP2_FLOW, LEVEL1, LEVEL0, OUT_TRAP, LEVEL2);
      bus(1, ADDR_FINE_TRAP, 32'h0);
      bus(1, ADDR_SYS_CONTROL, 32'h1);
      bus(1, ADDR_HYP_CONFIG, 32'h7);
      iss(ENC_OP2_FLOW, LEVEL0, LEVEL0, OUT_TRAP, LEVEL2);
      bus(1, ADDR_HYP_CONFIG, 32'h0);
      slow <= 1'b1;
      iss(ENC_OP2_PREFETCH, LEVEL0, LEVEL0, OUT_PERFORM, 2'h0);
      chk("req", restrictReq[41:21], {4'hF, 1'b0, curSpaceTag});
      chk("guest", restrictReq.guestIdent, 16'h0042);
      barrierReq <= 1'b1;
      @(posedge clk);
      barrierReq <= 1'b0;
      for (int n = 0; n < 20 && barrierDone !== 1'b1; n++) @(negedge clk);
      chk("barrierDone", barrierDone, 1'b1);
      chk("secPair", restrictReq.secPair, PAIR_NONSECURE);
      // a barrier with nothing outstanding completes at once
      @(posedge clk);
      barrierReq <= 1'b1;
      @(posedge clk);
      barrierReq <= 1'b0;
      @(negedge clk);
      chk("idle barrierDone", barrierDone, 1'b1);
      @(posedge clk);
      // root pair naming a lower target is a nop at level 3
      curSecurity <= PAIR_ROOT;
      opPair = PAIR_ROOT;
      iss(ENC_OP2_FLOW, LEVEL3, LEVEL0, OUT_NOP, 2'h0);
      curSecurity <= PAIR_REALM;
      iss(ENC_OP2_FLOW, LEVEL3, LEVEL3, OUT_PERFORM, 2'h0);
      chk("secPair", restrictReq.secPair, PAIR_REALM);
      // without the realm option the upper pair bit is dropped
      bus(1, ADDR_FEATURES, 32'h1D);
      curSecurity <= PAIR_NONSECURE;
      iss(ENC_OP2_FLOW, LEVEL3, LEVEL3, OUT_PERFORM, 2'h0);
      chk("secPair", restrictReq.secPair, PAIR_NONSECURE);
      bus(1, ADDR_FEATURES, 32'h1E);
      iss(ENC_OP2_PREFETCH, LEVEL2, LEVEL0, OUT_UNDEF, 2'h0);
      repeat (3) @(posedge clk);
      chk("queue", expQ.size(), 0);
      complete_run();
   end
endmodule : prediction_restrict_ctx_decode_test
`default_nettype wire
